// ==== include/fic_pkg.sv ====
// package for the floating-point to/from integer conversion datapath
package fic_pkg;

    // operations presented by the issue logic
    typedef enum logic [2:0] {
        FIC_OP_TO_W,     // to 32-bit integer, status rounding mode
        FIC_OP_TO_WZ,    // to 32-bit integer, toward zero
        FIC_OP_TO_D,     // to 64-bit integer, status rounding mode
        FIC_OP_TO_DZ,    // to 64-bit integer, toward zero
        FIC_OP_FROM_D    // 64-bit integer to double
    } fic_op_t;

    // rounding modes
    localparam logic [1:0] FIC_RM_NEAR = 2'h0;
    localparam logic [1:0] FIC_RM_ZERO = 2'h1;
    localparam logic [1:0] FIC_RM_POS  = 2'h2;
    localparam logic [1:0] FIC_RM_NEG  = 2'h3;

    // double-precision format figures
    localparam logic [10:0]        FIC_EXP_SPECIAL = 11'h7ff;   // 2047
    localparam logic [10:0]        FIC_EXP_LARGE   = 11'h43e;   // 1086
    localparam logic [10:0]        FIC_BIAS        = 11'h3ff;   // 1023
    localparam logic [10:0]        FIC_INT_TOP     = 11'h03f;   // 63
    localparam logic signed [12:0] FIC_DENORM_EXP  = -13'sh03fe; // -1022
    localparam int                 FIC_QUIET_BIT   = 51;        // fraction bit 12

    // saturation and range values
    localparam logic [63:0] FIC_W_MAX  = 64'h0000_0000_7fff_ffff;
    localparam logic [63:0] FIC_W_MIN  = 64'hffff_ffff_8000_0000;
    localparam logic [63:0] FIC_D_MAX  = 64'h7fff_ffff_ffff_ffff;
    localparam logic [63:0] FIC_D_MIN  = 64'h8000_0000_0000_0000;
    localparam logic [64:0] FIC_W_POS  = 65'h0_7fff_ffff;
    localparam logic [64:0] FIC_W_NEG  = 65'h0_8000_0000;
    localparam logic [64:0] FIC_D_POS  = 65'h0_7fff_ffff_ffff_ffff;
    localparam logic [64:0] FIC_D_NEG  = 65'h0_8000_0000_0000_0000;

    // result class codes
    localparam logic [4:0] FIC_CLS_PZERO = 5'h02;
    localparam logic [4:0] FIC_CLS_PNORM = 5'h04;
    localparam logic [4:0] FIC_CLS_NNORM = 5'h08;

    // register offsets (byte addresses)
    localparam logic [3:0] FIC_OFS_STATUS = 4'h0;
    localparam logic [3:0] FIC_OFS_RES_LO = 4'h4;
    localparam logic [3:0] FIC_OFS_RES_HI = 4'h8;

    // status register fields
    localparam int FIC_F_RM     = 0;   // [1:0]
    localparam int FIC_F_VE     = 2;
    localparam int FIC_F_FR     = 3;
    localparam int FIC_F_FI     = 4;
    localparam int FIC_F_XX     = 5;
    localparam int FIC_F_INVALID_CONVERSION_FLAG  = 6;
    localparam int FIC_F_SIGNALING_NAN_INVALID_FLAG = 7;
    localparam int FIC_F_CLS    = 8;   // [12:8]

    // reset values
    localparam logic [1:0] FIC_RST_RM = 2'h0;
    localparam logic       FIC_RST_VE = 1'b0;

    typedef struct packed {
        fic_op_t     op;
        logic [63:0] operand;
    } fic_req_t;

    typedef struct packed {
        logic fr;
        logic fi;
        logic xx;
        logic invalid_conversion_flag;
        logic signaling_nan_invalid_flag;
    } fic_flags_t;

    typedef struct packed {
        logic [63:0] result;
        logic        write_en;
        fic_flags_t  flags;
        logic        class_valid;
        logic [4:0]  class_code;
    } fic_rsp_t;

endpackage : fic_pkg

// ==== rtl/fic_convert.sv ====
// conversion datapath: double to 32/64-bit integer and 64-bit integer to double
//
// Functional notes
// [RULE1] word convert targets signed 32 bits; rounding from status, zero variant uses 01
// [RULE2] doubleword convert targets signed 64 bits; zero variant forces mode 01
// [RULE3] exponent 2047 with zero fraction is infinity: clear rounded, inexact; set invalid
// [RULE4] exponent 2047, fraction bit 12 clear: signaling nan, set both invalid flags
// [RULE5] exponent 2047, fraction bit 12 set: quiet nan, set invalid conversion
// [RULE6] exponent field above 1086 takes the large-operand path
// [RULE7] unbiased exponent is field minus 1023, or -1022 with hidden bit zero
// [RULE8] after right alignment by 63 minus exponent, any lost bits set sticky inexact
// [RULE9] nearest mode increments when guard and any of lsb, round, sticky
// [RULE10] positive-infinity mode increments positive values with any lost bits
// [RULE11] negative-infinity mode increments negative magnitudes with any lost bits
// [RULE12] rounded flag takes the increment; inexact flag takes guard or round or sticky
// [RULE13] negative sources are negated after rounding, before range check and placement; code range-checks the magnitude, then negates
// [RULE14] results beyond signed 32 or 64 bit range take the large-operand path
// [RULE15] word result sits in low 32 bits; doubleword writes all 64; class undefined
// [RULE16] infinity with trapping off saturates to max or min by sign
// [RULE17] nan with trapping off returns the most negative integer of the width
// [RULE18] integer to double starts at exponent 63, negates, normalises left
// [RULE19] zero integer gives positive zero, class plus zero, rounded and inexact cleared
// [RULE20] float rounding uses bit 52 lsb, 53 guard, 54 round, 55-63 sticky
// [RULE21] integer conversion sets sticky inexact when any rounding bit is nonzero
// [RULE22] double result is sign, exponent plus 1023, 52 fraction bits; signed normal class
// [RULE23] issue presents operand, op and valid; device answers result and flags with strobe
`timescale 1ns/1ps

module fic_convert
    import fic_pkg::*;
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    // issue side
    input  wire logic        req_valid_i,
    input  wire fic_req_t    req_i,
    // register file side
    output logic             rsp_valid_o,
    output fic_rsp_t         rsp_o,
    // ahb-lite slave
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic             hreadyout_o,
    output logic             hresp_o,
    output logic [31:0]      hrdata_o
);

    ////////////////////////////////////////////////////////////////////////////////
    // status register state

    logic [1:0]  rm_q;
    logic        ve_q;
    logic        fr_q;
    logic        fi_q;
    logic        xx_q;
    logic        invalid_conversion_flag_q;
    logic        signaling_nan_invalid_flag_q;
    logic [4:0]  cls_q;
    logic [63:0] res_q;
    fic_rsp_t    rsp_q;
    logic        rsp_valid_q;
    fic_rsp_t    rsp_d;

    // rounding increment decision shared by integer and float rounding
    function automatic logic rnd_inc(input logic [1:0] rm, input logic sgn,
                                     input logic lsb, input logic g, input logic r,
                                     input logic x);
        logic lost;
        lost = g | r | x;
        unique case (rm)
            FIC_RM_NEAR: rnd_inc = g & (lsb | r | x);   // see [RULE9]
            FIC_RM_ZERO: rnd_inc = 1'b0;
            FIC_RM_POS:  rnd_inc = ~sgn & lost;         // see [RULE10]
            FIC_RM_NEG:  rnd_inc = sgn & lost;          // see [RULE11]
        endcase
    endfunction : rnd_inc

    ////////////////////////////////////////////////////////////////////////////////
    // conversion datapath

    logic                sgn;
    logic [10:0]         ef;
    logic                is_word;
    logic [1:0]          rm;
    logic signed [12:0]  unb;
    logic signed [12:0]  sh;
    logic [52:0]         mant;
    logic [127:0]        wide;
    logic [127:0]        shifted;
    logic                lost;
    logic                g;
    logic                r;
    logic                x;
    logic                inc;
    logic [64:0]         mag;
    logic                ovf;
    logic [63:0]         imag;
    logic [5:0]          lz;
    logic [63:0]         norm;
    logic [53:0]         sum;
    logic [10:0]         bexp;

    always_comb begin
        rsp_d   = '0;
        sgn     = req_i.operand[63];
        ef      = req_i.operand[62:52];
        is_word = (req_i.op == FIC_OP_TO_W) || (req_i.op == FIC_OP_TO_WZ);   // see [RULE1]
        // zero variants ignore the status mode
        rm = ((req_i.op == FIC_OP_TO_WZ) || (req_i.op == FIC_OP_TO_DZ)) ?
             FIC_RM_ZERO : rm_q;                                             // see [RULE2]
        // hidden bit and unbiased exponent
        mant = {(ef != 11'h000), req_i.operand[51:0]};
        unb  = (ef != 11'h000) ? ($signed({2'b00, ef}) - $signed({2'b00, FIC_BIAS}))
                               : FIC_DENORM_EXP;                             // see [RULE7]
        sh   = $signed({2'b00, FIC_INT_TOP}) - unb;
        wide = {mant, 75'h0};
        // align so the integer sits in bits 127:64; shifts past the field are all sticky
        if (sh > 13'sh007f) begin
            shifted = '0;
            lost    = |mant;
        end else if (sh < 13'sh0000) begin
            shifted = '0;
            lost    = 1'b0;
        end else begin
            shifted = wide >> sh[6:0];
            lost    = (shifted << sh[6:0]) != wide;
        end
        g    = shifted[63];
        r    = shifted[62];
        x    = (|shifted[61:0]) | lost;
        inc  = rnd_inc(rm, sgn, shifted[64], g, r, x);
        mag  = {1'b0, shifted[127:64]} + {64'h0, inc};
        // range check on magnitude, allowing one more on the negative side
        if (is_word) begin
            ovf = sgn ? (mag > FIC_W_NEG) : (mag > FIC_W_POS);               // see [RULE14]
        end else begin
            ovf = sgn ? (mag > FIC_D_NEG) : (mag > FIC_D_POS);               // see [RULE14]
        end
        // integer to double operands
        imag = sgn ? (~req_i.operand + 64'h1) : req_i.operand;               // see [RULE18]
        lz   = 6'h00;
        for (int i = 0; i < 64; i++) begin
            if (imag[i]) begin
                lz = 6'(63 - i);
            end
        end
        norm = imag << lz;                                                   // see [RULE18]
        sum  = {1'b0, norm[63:11]}
             + {53'h0, rnd_inc(rm_q, sgn, norm[11], norm[10], norm[9], |norm[8:0])};
        bexp = FIC_BIAS + FIC_INT_TOP - {5'h00, lz} + {10'h000, sum[53]};    // see [RULE20]

        if (req_i.op == FIC_OP_FROM_D) begin
            rsp_d.write_en    = 1'b1;
            rsp_d.class_valid = 1'b1;
            if (req_i.operand == 64'h0) begin
                rsp_d.result     = 64'h0;                                    // see [RULE19]
                rsp_d.class_code = FIC_CLS_PZERO;
            end else begin
                rsp_d.flags.fr = sum[53:0] != {1'b0, norm[63:11]};           // see [RULE12]
                rsp_d.flags.fi = norm[10] | norm[9] | (|norm[8:0]);          // see [RULE20]
                rsp_d.flags.xx = rsp_d.flags.fi;                             // see [RULE21]
                rsp_d.result   = {sgn, bexp, sum[51:0]};                     // see [RULE22]
                rsp_d.class_code = sgn ? FIC_CLS_NNORM : FIC_CLS_PNORM;      // see [RULE22]
            end
        end else if (ef == FIC_EXP_SPECIAL && req_i.operand[51:0] == 52'h0) begin
            // infinity saturates by sign and width
            rsp_d.flags.invalid_conversion_flag = 1'b1;                                        // see [RULE3]
            rsp_d.write_en    = ~ve_q;                                       // see [RULE16]
            if (is_word) begin
                rsp_d.result = sgn ? FIC_W_MIN : FIC_W_MAX;                  // see [RULE16]
            end else begin
                rsp_d.result = sgn ? FIC_D_MIN : FIC_D_MAX;                  // see [RULE16]
            end
        end else if (ef == FIC_EXP_SPECIAL) begin
            rsp_d.flags.invalid_conversion_flag  = 1'b1;                                       // see [RULE5]
            rsp_d.flags.signaling_nan_invalid_flag = ~req_i.operand[FIC_QUIET_BIT];              // see [RULE4]
            rsp_d.write_en     = ~ve_q;
            rsp_d.result       = is_word ? FIC_W_MIN : FIC_D_MIN;            // see [RULE17]
        end else if (ef > FIC_EXP_LARGE) begin
            // large operand: saturates like infinity, rounding flags cleared
            rsp_d.flags.invalid_conversion_flag = 1'b1;                                        // see [RULE6]
            rsp_d.write_en    = ~ve_q;
            if (is_word) begin
                rsp_d.result = sgn ? FIC_W_MIN : FIC_W_MAX;
            end else begin
                rsp_d.result = sgn ? FIC_D_MIN : FIC_D_MAX;
            end
        end else begin
            rsp_d.flags.xx = g | r | x;                                      // see [RULE8]
            if (ovf) begin
                rsp_d.flags.invalid_conversion_flag = 1'b1;                                    // see [RULE14]
                rsp_d.write_en    = ~ve_q;
                if (is_word) begin
                    rsp_d.result = sgn ? FIC_W_MIN : FIC_W_MAX;
                end else begin
                    rsp_d.result = sgn ? FIC_D_MIN : FIC_D_MAX;
                end
            end else begin
                rsp_d.flags.fr = inc;                                        // see [RULE12]
                rsp_d.flags.fi = g | r | x;                                  // see [RULE12]
                rsp_d.write_en = 1'b1;
                // full 64-bit pattern; the word form only defines the low half
                rsp_d.result   = sgn ? (~mag[63:0] + 64'h1) : mag[63:0];     // see [RULE13]
            end                                                              // see [RULE15]
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // response register: one cycle from request to answer

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rsp_valid_q <= 1'b0;
            rsp_q       <= '0;
        end else begin
            rsp_valid_q <= req_valid_i;                                      // see [RULE23]
            if (req_valid_i) begin
                rsp_q <= rsp_d;
            end
        end
    end

    assign rsp_valid_o = rsp_valid_q;
    assign rsp_o       = rsp_q;

    ////////////////////////////////////////////////////////////////////////////////
    // ahb-lite slave: zero wait states, always okay

    logic       a_wr_q;
    logic       a_rd_q;
    logic [3:0] a_addr_q;
    logic       st_wr;

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            a_wr_q   <= 1'b0;
            a_rd_q   <= 1'b0;
            a_addr_q <= 4'h0;
        end else if (hready_i) begin
            a_wr_q   <= hsel_i & htrans_i[1] & hwrite_i;
            a_rd_q   <= hsel_i & htrans_i[1] & ~hwrite_i;
            a_addr_q <= (haddr_i[31:4] == 28'h0) ? haddr_i[3:0] : 4'hc;
        end
    end

    assign st_wr       = a_wr_q && (a_addr_q == FIC_OFS_STATUS);
    assign hreadyout_o = 1'b1;
    assign hresp_o     = 1'b0;

    // read mux on flops; unmapped offsets read zero
    always_comb begin
        hrdata_o = 32'h0;
        if (a_rd_q) begin
            unique case (a_addr_q)
                FIC_OFS_STATUS: hrdata_o = {19'h0, cls_q, signaling_nan_invalid_flag_q, invalid_conversion_flag_q, xx_q,
                                            fi_q, fr_q, ve_q, rm_q};
                FIC_OFS_RES_LO: hrdata_o = res_q[31:0];
                FIC_OFS_RES_HI: hrdata_o = res_q[63:32];
                default:        hrdata_o = 32'h0;
            endcase
        end
    end

    // control fields written by software
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rm_q <= FIC_RST_RM;
            ve_q <= FIC_RST_VE;
        end else if (st_wr) begin
            rm_q <= hwdata_i[FIC_F_RM +: 2];
            ve_q <= hwdata_i[FIC_F_VE];
        end
    end

    // per-operation flags overwritten; sticky flags write-one-to-clear, set wins
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            fr_q     <= 1'b0;
            fi_q     <= 1'b0;
            xx_q     <= 1'b0;
            invalid_conversion_flag_q  <= 1'b0;
            signaling_nan_invalid_flag_q <= 1'b0;
            cls_q    <= 5'h00;
            res_q    <= 64'h0;
        end else begin
            if (req_valid_i) begin
                fr_q <= rsp_d.flags.fr;                                      // see [RULE12]
                fi_q <= rsp_d.flags.fi;
                if (rsp_d.class_valid) begin
                    cls_q <= rsp_d.class_code;
                end
                if (rsp_d.write_en) begin
                    res_q <= rsp_d.result;
                end
            end
            xx_q     <= (xx_q & ~(st_wr & hwdata_i[FIC_F_XX]))
                      | (req_valid_i & rsp_d.flags.xx);                      // see [RULE8]
            invalid_conversion_flag_q  <= (invalid_conversion_flag_q & ~(st_wr & hwdata_i[FIC_F_INVALID_CONVERSION_FLAG]))
                      | (req_valid_i & rsp_d.flags.invalid_conversion_flag);
            signaling_nan_invalid_flag_q <= (signaling_nan_invalid_flag_q & ~(st_wr & hwdata_i[FIC_F_SIGNALING_NAN_INVALID_FLAG]))
                      | (req_valid_i & rsp_d.flags.signaling_nan_invalid_flag);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    property p_zero_variant;
        req_valid_i && (req_i.op inside {FIC_OP_TO_WZ, FIC_OP_TO_DZ}) |=> !rsp_o.flags.fr;
    endproperty
    a_zero_variant: assert property (p_zero_variant) // see [RULE1] [RULE2]
        else $error("toward-zero conversion rounded up");

    property p_inf_flags;
        req_valid_i && req_i.op != FIC_OP_FROM_D && req_i.operand[62:52] == FIC_EXP_SPECIAL
        && req_i.operand[51:0] == 52'h0
        |=> rsp_valid_o && rsp_o.flags.invalid_conversion_flag && !rsp_o.flags.fr && !rsp_o.flags.fi;
    endproperty
    a_inf_flags: assert property (p_inf_flags) // see [RULE3]
        else $error("infinity flags wrong");

    property p_snan;
        req_valid_i && req_i.op == FIC_OP_TO_D && req_i.operand[62:51] == 12'hffe
        && req_i.operand[50:0] != 51'h0 |=> rsp_o.flags.signaling_nan_invalid_flag && rsp_o.flags.invalid_conversion_flag;
    endproperty
    a_snan: assert property (p_snan) // see [RULE4]
        else $error("signaling nan flags missing");

    property p_nan_result;
        req_valid_i && req_i.op == FIC_OP_TO_W && req_i.operand[62:51] == 12'hfff && !ve_q
        |=> rsp_o.write_en && rsp_o.result[31:0] == 32'h8000_0000 && !rsp_o.flags.signaling_nan_invalid_flag;
    endproperty
    a_nan_result: assert property (p_nan_result) // see [RULE17]
        else $error("nan result wrong");

    property p_inf_sat;
        req_valid_i && req_i.op == FIC_OP_TO_W && req_i.operand == 64'h7ff0_0000_0000_0000
        && !ve_q |=> rsp_o.result[31:0] == 32'h7fff_ffff;
    endproperty
    a_inf_sat: assert property (p_inf_sat) // see [RULE16]
        else $error("infinity not saturated");

    property p_xx_sticky;
        rsp_valid_o && rsp_o.flags.xx |-> xx_q;
    endproperty
    a_xx_sticky: assert property (p_xx_sticky) // see [RULE8]
        else $error("sticky inexact not recorded");

    property p_fr_fi;
        rsp_valid_o && rsp_o.flags.fr |-> rsp_o.flags.fi && fr_q;
    endproperty
    a_fr_fi: assert property (p_fr_fi) // see [RULE12]
        else $error("rounded without inexact");

    property p_zero_int;
        req_valid_i && req_i.op == FIC_OP_FROM_D && req_i.operand == 64'h0
        |=> rsp_o.result == 64'h0 && rsp_o.class_code == FIC_CLS_PZERO && !rsp_o.flags.fi;
    endproperty
    a_zero_int: assert property (p_zero_int) // see [RULE19]
        else $error("zero integer conversion wrong");

    property p_neg_one;
        req_valid_i && req_i.op == FIC_OP_FROM_D && req_i.operand == 64'hffff_ffff_ffff_ffff
        |=> rsp_o.result == 64'hbff0_0000_0000_0000 && rsp_o.class_code == FIC_CLS_NNORM;
    endproperty
    a_neg_one: assert property (p_neg_one) // see [RULE22]
        else $error("minus one not converted");

    property p_tie_even;
        req_valid_i && req_i.op == FIC_OP_TO_D && rm_q == FIC_RM_NEAR
        && req_i.operand == 64'h4004_0000_0000_0000 |=> rsp_o.result == 64'h2;
    endproperty
    a_tie_even: assert property (p_tie_even) // see [RULE9]
        else $error("tie not rounded to even");

    property p_answer;
        req_valid_i |=> rsp_valid_o ##1 !rsp_valid_o || $past(req_valid_i);
    endproperty
    a_answer: assert property (p_answer) // see [RULE23]
        else $error("completion strobe misplaced");

    c_from_neg: cover property (req_valid_i && req_i.op == FIC_OP_FROM_D && req_i.operand[63]);
    c_snan:     cover property (rsp_valid_o && rsp_o.flags.signaling_nan_invalid_flag);
    c_rounded:  cover property (rsp_valid_o && rsp_o.flags.fr);

endmodule : fic_convert

// ==== dv/fic_issue_model.sv ====
// issue logic and register file model facing the conversion datapath
`timescale 1ns/1ps
module fic_issue_model
    import fic_pkg::*;
(
    // clock and reset
    input  wire logic     clk_i,
    input  wire logic     sys_rst_i,
    // command from the bench
    input  wire logic     cmd_valid_i,
    input  wire fic_req_t cmd_i,
    // datapath side
    output logic          req_valid_o,
    output fic_req_t      req_o,
    input  wire logic     rsp_valid_i,
    input  wire fic_rsp_t rsp_i,
    // register file copy
    output logic [63:0]   fpr_o
);
    //////////////////////////////
    // issue stage; idle operand flips so a stale sample never passes
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            req_valid_o <= 1'b0;
            req_o       <= '0;
        end else begin
            req_valid_o   <= cmd_valid_i;
            req_o.op      <= cmd_i.op;
            req_o.operand <= cmd_valid_i ? cmd_i.operand : ~req_o.operand;
        end
    end
    // register file takes only results the datapath marks for writing
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i)
            fpr_o <= '0;
        else if (rsp_valid_i && rsp_i.write_en)
            fpr_o <= rsp_i.result;
    end
endmodule : fic_issue_model

// ==== dv/tb.sv ====
// self-checking bench for the conversion datapath
`timescale 1ns/1ps
module tb
    import fic_pkg::*;
;
    logic        clk_i = 1'b0, sys_rst_i = 1'b1, cmd_valid = 1'b0;
    fic_req_t    cmd = '0, req;
    fic_rsp_t    rsp;
    logic        req_valid, rsp_valid, hwrite = 1'b0, hready, hresp;
    logic [63:0] fpr;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
    logic [1:0]  htrans = 2'h0;
    int          failures = 0, num_checks = 0;
    always #2 clk_i = ~clk_i;
    //////////////////////////////
    fic_issue_model fic_issue_model_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .cmd_valid_i(cmd_valid), .cmd_i(cmd), .req_valid_o(req_valid), .req_o(req),
        .rsp_valid_i(rsp_valid), .rsp_i(rsp), .fpr_o(fpr));
    fic_convert fic_convert_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .req_valid_i(req_valid), .req_i(req), .rsp_valid_o(rsp_valid), .rsp_o(rsp),
        .hsel_i(1'b1), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready), .hreadyout_o(hready),
        .hresp_o(hresp), .hrdata_o(hrdata));
    //////////////////////////////
    task automatic give_verdict();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // single ahb-lite transfer; waits on hready, never on a fixed count
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                       output logic [31:0] q);
        int n;
        @(posedge clk_i);
        htrans <= 2'h2;
        haddr  <= a;
        hwrite <= wr;
        n = 0;
        do begin @(posedge clk_i); n++; end while (hready !== 1'b1 && n < 20);
        htrans <= 2'h0;
        hwdata <= wd;
        do begin @(posedge clk_i); n++; end while (hready !== 1'b1 && n < 40);
        q = hrdata;
        chk(64'(hresp), 64'h0);
        if (n >= 40) begin failures++; give_verdict(); end
    endtask : ahb
    // one request; word results are judged on the low half only
    task automatic conv(input fic_op_t op, input logic [63:0] opnd, input logic [63:0] res,
                        input logic [4:0] fl, input logic [4:0] cls = 5'h0);
        int n;
        logic [63:0] m;
        m = (op == FIC_OP_TO_W || op == FIC_OP_TO_WZ) ? 64'hffffffff : '1;
        @(posedge clk_i);
        cmd_valid <= 1'b1;
        cmd       <= '{op, opnd};
        @(posedge clk_i);
        cmd_valid <= 1'b0;
        n = 0;
        while (rsp_valid !== 1'b1) begin
            @(posedge clk_i);
            #1;
            n++;
            if (n > 10) begin failures++; give_verdict(); end
        end
        chk(rsp.result & m, res & m);
        chk(64'(rsp.flags), 64'(fl));
        chk(64'(rsp.class_valid), 64'(op == FIC_OP_FROM_D));
        if (op == FIC_OP_FROM_D)
            chk(64'(rsp.class_code), 64'(cls));
    endtask : conv
    //////////////////////////////
    task automatic t_reset();
        ahb(1'b0, 32'h0, 32'h0, rd);
        chk(64'(rd), 64'h0);
        ahb(1'b1, 32'hc, 32'h3, rd);
        ahb(1'b0, 32'hc, 32'h0, rd);
        chk(64'(rd), 64'h0);
    endtask : t_reset
    task automatic t_round();
        conv(FIC_OP_TO_D, 64'h4004000000000000, 64'h2, 5'h0c);
        conv(FIC_OP_TO_D, 64'h400c000000000000, 64'h4, 5'h1c);
        conv(FIC_OP_TO_D, 64'hc004000000000000, 64'hfffffffffffffffe, 5'h0c);
        ahb(1'b1, 32'h0, 32'(FIC_RM_POS), rd);
        conv(FIC_OP_TO_D, 64'h4004000000000000, 64'h3, 5'h1c);
        conv(FIC_OP_TO_D, 64'hc004000000000000, 64'hfffffffffffffffe, 5'h0c);
        conv(FIC_OP_TO_D, 64'h1, 64'h1, 5'h1c);
        ahb(1'b1, 32'h0, 32'(FIC_RM_NEG), rd);
        conv(FIC_OP_TO_D, 64'hc004000000000000, 64'hfffffffffffffffd, 5'h1c);
        ahb(1'b0, 32'h4, 32'h0, rd);
        chk(64'(rd), 64'hfffffffd);
        conv(FIC_OP_TO_D, 64'h4004000000000000, 64'h2, 5'h0c);
        conv(FIC_OP_TO_DZ, 64'hc004000000000000, 64'hfffffffffffffffe, 5'h0c);
        conv(FIC_OP_TO_W, 64'hc004000000000000, 64'hfffffffd, 5'h1c);
        conv(FIC_OP_TO_WZ, 64'hc004000000000000, 64'hfffffffe, 5'h0c);
    endtask : t_round
    task automatic t_special();
        conv(FIC_OP_TO_W, 64'h7ff0000000000000, 64'h7fffffff, 5'h02);
        conv(FIC_OP_TO_D, 64'hfff0000000000000, FIC_D_MIN, 5'h02);
        conv(FIC_OP_TO_D, 64'h7ff0000000000001, FIC_D_MIN, 5'h03);
        conv(FIC_OP_TO_W, 64'h7ff8000000000000, 64'h80000000, 5'h02);
    endtask : t_special
    task automatic t_range();
        ahb(1'b1, 32'h0, 32'(FIC_RM_NEAR), rd);
        conv(FIC_OP_TO_D, 64'h43f0000000000000, FIC_D_MAX, 5'h02);
        conv(FIC_OP_TO_D, 64'hc3e0000000000000, FIC_D_MIN, 5'h00);
        conv(FIC_OP_TO_W, 64'h41e0000000000000, 64'h7fffffff, 5'h02);
        conv(FIC_OP_TO_W, 64'h41dfffffffe00000, 64'h7fffffff, 5'h06);
        conv(FIC_OP_TO_W, 64'hc1e0000000000000, 64'h80000000, 5'h00);
        conv(FIC_OP_TO_D, 64'h1, 64'h0, 5'h0c);
    endtask : t_range
    task automatic t_from();
        conv(FIC_OP_FROM_D, 64'h0, 64'h0, 5'h00, FIC_CLS_PZERO);
        conv(FIC_OP_FROM_D, '1, 64'hbff0000000000000, 5'h00, FIC_CLS_NNORM);
        conv(FIC_OP_FROM_D, 64'h20000000000001, 64'h4340000000000000, 5'h0c, 5'h4);
        conv(FIC_OP_FROM_D, 64'h20000000000003, 64'h4340000000000002, 5'h1c, 5'h4);
        conv(FIC_OP_FROM_D, FIC_D_MAX, 64'h43e0000000000000, 5'h1c, 5'h04);
    endtask : t_from
    // sticky clear, trap enable and result registers
    task automatic t_regs();
        ahb(1'b1, 32'h0, 32'he0, rd);
        ahb(1'b0, 32'h0, 32'h0, rd);
        chk(64'(rd), 64'h418);
        conv(FIC_OP_FROM_D, 64'h1, 64'h3ff0000000000000, 5'h00, FIC_CLS_PNORM);
        ahb(1'b1, 32'h0, 32'h4, rd);
        conv(FIC_OP_TO_D, 64'h7ff0000000000001, FIC_D_MIN, 5'h03);
        chk(64'(rsp.write_en), 64'h0);
        chk(fpr, 64'h3ff0000000000000);
        ahb(1'b0, 32'h0, 32'h0, rd);
        chk(64'(rd), 64'h4c4);
        ahb(1'b0, 32'h8, 32'h0, rd);
        chk(64'(rd), 64'h3ff00000);
    endtask : t_regs
    //////////////////////////////
    initial begin
        repeat (20) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        t_reset();
        t_round();
        t_special();
        t_range();
        t_from();
        t_regs();
        give_verdict();
    end
endmodule : tb
